/* src/sbs_pkg.sv */
// constants and types of the serial bus status flag block
package sbs_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'hbc;
  localparam logic [7:0] ADDR_PORTMODE = 8'hf8;
  localparam logic [7:0] ADDR_CTRL = 8'hc0;
  localparam logic [7:0] ADDR_IEN = 8'hc4;
  localparam logic [7:0] ADDR_RXDATA = 8'hc8;
  localparam logic [7:0] ADDR_TXDATA = 8'hcc;
  // status bit positions
  localparam int ST_GCALL = 0;
  localparam int ST_AAS = 1;
  localparam int ST_ALOV = 2;
  localparam int ST_STOP = 3;
  localparam int ST_NACK = 4;
  localparam int ST_RECEIVE_DATA_FULL_FLAG = 5;
  localparam int ST_TRANSMIT_END_FLAG = 6;
  localparam int ST_TRANSMIT_DATA_EMPTY_FLAG = 7;
  // port mode bit positions
  localparam int PM_PINSEL = 3;
  localparam int PM_FUNC = 7;
  // control bit positions
  localparam int CT_SYNC = 0;
  localparam int CT_MST = 1;
  localparam int CT_TRS = 2;
  localparam int CT_ACKNOWLEDGE_CHECK_ENABLE = 3;
  localparam int CT_SVA = 8;
  // interrupt enable bit positions
  localparam int IE_TIE = 0;
  localparam int IE_TEIE = 1;
  localparam int IE_RIE = 2;
  localparam int IE_STOP_INTERRUPT_ENABLE = 3;
  localparam int IE_NAKIE = 4;
  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_PORTMODE = 8'h00;
  localparam logic [14:0] RST_CTRL = 15'h0000;
  localparam logic [4:0] RST_IEN = 5'h00;
  // bit counts: rise index of the ninth clock and the last sync bit
  localparam logic [3:0] CNT_NINTH = 4'h8;
  localparam logic [3:0] CNT_SYNC_LAST = 4'h7;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

  typedef struct packed {
    logic txEmpty;
    logic txEnd;
    logic rxFull;
    logic stopDet;
    logic nackArb;
  } sbs_req_t;
endpackage

/* src/sbs_flag_logic.sv */
// status flags, port mode and apb registers of the serial bus interface
// What this block does
// - general call flag set on general call first frame, slave receive only
// - own address flag set when first frame matches own address, slave receive only
// - master transmit: driven sda differs from pin at scl rise, arbitration lost
// - master: start seen while own sda held high, arbitration lost
// - sync format: last bit arrives with receive full still set, overrun
// - stop flag set on stop condition after a frame
// - no acknowledge flag set on missing ack when ack check enabled
// - receive full set when received byte enters receive data register
// - receive full cleared by reading receive data register
// - i2c: transmit end set at ninth scl rise if transmit empty
// - transmit empty set when data moves into shift register
// - transmit empty set when software sets transmit select
// - transmit empty set when device generates a start
// - transmit empty set on slave receive to slave transmit change
// - writing transmit data clears transmit end and transmit empty
// - overrun shares the arbitration lost request in sync format
// - function switch routes pins: 0 sync unit, 1 i2c
// - pin choice: 0 selects input a, 1 selects input b
// - each request is its flag and enable both set, nackArb either of two flags; the stop request also needs i2c format
`timescale 1ns/1ps
`default_nettype none
module sbs_flag_logic (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus pins, asynchronous
  input wire logic sclIn,
  input wire logic sdaIn,
  // slave select pins, asynchronous
  input wire logic selectInA,
  input wire logic selectInB,
  // transfer engine, same clock
  input wire logic sdaDrive,
  input wire logic rxDone,
  input wire logic [7:0] rxByte,
  input wire logic rxFirst,
  input wire logic txLoad,
  // outputs
  output logic [7:0] txData,
  output logic i2cSelect,
  output logic slaveSelect,
  output var sbs_pkg::sbs_req_t req
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic rstMeta_r;
  logic rstN_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstN_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r <= rstMeta_r;
    end
  end

  // pin synchronisers: scl, sda, select a, select b
  logic [3:0] pinRaw;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  assign pinRaw = {selectInB, selectInA, sdaIn, sclIn};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk or negedge rstN_r) begin
        if (!rstN_r) begin
          sync1_r[g] <= 1'b1;
          sync2_r[g] <= 1'b1;
        end else begin
          sync1_r[g] <= pinRaw[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  logic sclS;
  logic sdaS;
  logic sclPrev_r;
  logic sdaPrev_r;
  assign sclS = sync2_r[0];
  assign sdaS = sync2_r[1];
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
    end
  end

  logic sclRise;
  logic startDet;
  logic stopDet;
  assign sclRise = sclS & ~sclPrev_r;
  assign startDet = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
  assign stopDet = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

  // registers
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] portMode_r;
  logic [14:0] ctrl_r;
  logic [4:0] ien_r;
  logic [7:0] rxData_r;
  logic [7:0] txData_r;
  logic [7:0] readMask_r;

  logic setup;
  logic access;
  logic wrAcc;
  logic rdAcc;
  logic mapped;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wrAcc = access & pwrite;
  assign rdAcc = access & ~pwrite;
  assign mapped = hit(paddr, sbs_pkg::ADDR_STATUS)
    | hit(paddr, sbs_pkg::ADDR_PORTMODE) | hit(paddr, sbs_pkg::ADDR_CTRL)
    | hit(paddr, sbs_pkg::ADDR_IEN) | hit(paddr, sbs_pkg::ADDR_RXDATA)
    | hit(paddr, sbs_pkg::ADDR_TXDATA);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  logic syncFmt;
  logic master;
  logic transmit_receive_select;
  logic acknowledge_check_enable;
  logic [6:0] ownAddr;
  assign syncFmt = ctrl_r[sbs_pkg::CT_SYNC];
  assign master = ctrl_r[sbs_pkg::CT_MST];
  assign transmit_receive_select = ctrl_r[sbs_pkg::CT_TRS];
  assign acknowledge_check_enable = ctrl_r[sbs_pkg::CT_ACKNOWLEDGE_CHECK_ENABLE];
  assign ownAddr = ctrl_r[sbs_pkg::CT_SVA +: 7];

  // read data loaded during setup, valid through access
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      case (paddr)
        sbs_pkg::ADDR_STATUS: prdata <= {24'h0, status_r};
        sbs_pkg::ADDR_PORTMODE: prdata <= {24'h0, portMode_r};
        sbs_pkg::ADDR_CTRL: prdata <= {17'h0, ctrl_r};
        sbs_pkg::ADDR_IEN: prdata <= {27'h0, ien_r};
        sbs_pkg::ADDR_RXDATA: prdata <= {24'h0, rxData_r};
        sbs_pkg::ADDR_TXDATA: prdata <= {24'h0, txData_r};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // bits seen as 1 by the last status read, dropped once written 0
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      readMask_r <= 8'h00;
    end else if (rdAcc && hit(paddr, sbs_pkg::ADDR_STATUS)) begin
      readMask_r <= prdata[7:0];
    end else if (wrAcc && hit(paddr, sbs_pkg::ADDR_STATUS)) begin
      readMask_r <= readMask_r & pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      portMode_r <= sbs_pkg::RST_PORTMODE;
    end else if (wrAcc && hit(paddr, sbs_pkg::ADDR_PORTMODE)) begin
      portMode_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      ien_r <= sbs_pkg::RST_IEN;
    end else if (wrAcc && hit(paddr, sbs_pkg::ADDR_IEN)) begin
      ien_r <= pwdata[4:0];
    end
  end

  // slave receive, first frame, read bit: switch to slave transmit
  logic slaveRx;
  logic ownMatch;
  logic gcMatch;
  logic toSlaveTx;
  assign slaveRx = ~syncFmt & ~master & ~transmit_receive_select;
  assign ownMatch = rxDone & rxFirst & slaveRx & (rxByte[7:1] == ownAddr);
  assign gcMatch = rxDone & rxFirst & slaveRx
    & (rxByte[7:1] == sbs_pkg::GEN_CALL_ADDR);
  assign toSlaveTx = ownMatch & rxByte[0];

  logic trsSetSw;
  assign trsSetSw = wrAcc & hit(paddr, sbs_pkg::ADDR_CTRL)
    & pwdata[sbs_pkg::CT_TRS] & ~transmit_receive_select;

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      ctrl_r <= sbs_pkg::RST_CTRL;
    end else if (wrAcc && hit(paddr, sbs_pkg::ADDR_CTRL)) begin
      ctrl_r <= pwdata[14:0];
    end else if (toSlaveTx) begin
      ctrl_r[sbs_pkg::CT_TRS] <= 1'b1;
    end
  end

  logic txWrite;
  logic rxRead;
  assign txWrite = wrAcc & hit(paddr, sbs_pkg::ADDR_TXDATA);
  assign rxRead = rdAcc & hit(paddr, sbs_pkg::ADDR_RXDATA);

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      txData_r <= 8'h00;
    end else if (txWrite) begin
      txData_r <= pwdata[7:0];
    end
  end
  assign txData = txData_r;

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      rxData_r <= 8'h00;
    end else if (rxDone) begin
      rxData_r <= rxByte;
    end
  end

  // scl rise counter within a frame
  logic [3:0] bitCnt_r;
  logic ninth;
  logic syncLast;
  assign ninth = sclRise & ~syncFmt & (bitCnt_r == sbs_pkg::CNT_NINTH);
  assign syncLast = sclRise & syncFmt
    & (bitCnt_r == sbs_pkg::CNT_SYNC_LAST);
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      bitCnt_r <= 4'h0;
    end else if (startDet || ninth || syncLast) begin
      bitCnt_r <= 4'h0;
    end else if (sclRise) begin
      bitCnt_r <= bitCnt_r + 4'h1;
    end
  end

  // a frame completed since the last stop
  logic frameDone_r;
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      frameDone_r <= 1'b0;
    end else if (ninth) begin
      frameDone_r <= 1'b1;
    end else if (stopDet) begin
      frameDone_r <= 1'b0;
    end
  end

  // flag set and clear terms; set wins
  logic [7:0] setVec;
  logic [7:0] clrVec;
  logic arbSda;
  logic arbStart;
  logic ownStart;
  logic overrun;
  assign arbSda = ~syncFmt & master & transmit_receive_select & sclRise & (sdaDrive != sdaS);
  assign arbStart = ~syncFmt & master & startDet & sdaDrive;
  assign ownStart = ~syncFmt & master & startDet & ~sdaDrive;
  assign overrun = syncLast & status_r[sbs_pkg::ST_RECEIVE_DATA_FULL_FLAG];

  always_comb begin
    setVec = 8'h00;
    setVec[sbs_pkg::ST_GCALL] = gcMatch;
    setVec[sbs_pkg::ST_AAS] = ownMatch;
    setVec[sbs_pkg::ST_ALOV] = arbSda | arbStart | overrun;
    setVec[sbs_pkg::ST_STOP] = stopDet & frameDone_r;
    setVec[sbs_pkg::ST_NACK] = ninth & transmit_receive_select & acknowledge_check_enable & sdaS;
    setVec[sbs_pkg::ST_RECEIVE_DATA_FULL_FLAG] = rxDone;
    setVec[sbs_pkg::ST_TRANSMIT_END_FLAG] = (ninth & status_r[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG])
      | (syncLast & transmit_receive_select);
    setVec[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG] = txLoad
      | trsSetSw
      | ownStart
      | toSlaveTx;
  end

  always_comb begin
    clrVec = 8'h00;
    if (wrAcc && hit(paddr, sbs_pkg::ADDR_STATUS)) begin
      clrVec = ~pwdata[7:0] & readMask_r;
    end
    clrVec[sbs_pkg::ST_RECEIVE_DATA_FULL_FLAG] = clrVec[sbs_pkg::ST_RECEIVE_DATA_FULL_FLAG] | rxRead;
    clrVec[sbs_pkg::ST_TRANSMIT_END_FLAG] = clrVec[sbs_pkg::ST_TRANSMIT_END_FLAG] | txWrite;
    clrVec[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG] = clrVec[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG] | txWrite;
  end

  assign status_nxt = (status_r & ~clrVec) | setVec;
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      status_r <= sbs_pkg::RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  // pin routing
  assign i2cSelect = portMode_r[sbs_pkg::PM_FUNC];
  assign slaveSelect = portMode_r[sbs_pkg::PM_PINSEL] ? sync2_r[3]
    : sync2_r[2];

  // requests; stop request only in i2c format
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      req <= '0;
    end else begin
      req.txEmpty <= ien_r[sbs_pkg::IE_TIE]
        & status_nxt[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG];
      req.txEnd <= ien_r[sbs_pkg::IE_TEIE] & status_nxt[sbs_pkg::ST_TRANSMIT_END_FLAG];
      req.rxFull <= ien_r[sbs_pkg::IE_RIE] & status_nxt[sbs_pkg::ST_RECEIVE_DATA_FULL_FLAG];
      req.stopDet <= ien_r[sbs_pkg::IE_STOP_INTERRUPT_ENABLE] & ~syncFmt
        & status_nxt[sbs_pkg::ST_STOP];
      req.nackArb <= ien_r[sbs_pkg::IE_NAKIE]
        & (status_nxt[sbs_pkg::ST_ALOV] | status_nxt[sbs_pkg::ST_NACK]);
    end
  end

  // checks
  sequence s_txw;
    psel && penable && pwrite && paddr == sbs_pkg::ADDR_TXDATA;
  endsequence
  sequence s_load;
    txLoad && !txWrite;
  endsequence

  AST_GCALL: assert property (@(posedge clk) disable iff (!rstN_r)
    gcMatch |=> status_r[sbs_pkg::ST_GCALL])
    else $error("general call flag not set");
  AST_GCALL_MODE: assert property (@(posedge clk) disable iff (!rstN_r)
    (master || transmit_receive_select || syncFmt) && !status_r[sbs_pkg::ST_GCALL]
    |=> !status_r[sbs_pkg::ST_GCALL])
    else $error("general call outside slave receive");
  AST_AAS: assert property (@(posedge clk) disable iff (!rstN_r)
    ownMatch |=> status_r[sbs_pkg::ST_AAS])
    else $error("own address flag not set");
  AST_ARB: assert property (@(posedge clk) disable iff (!rstN_r)
    !syncFmt && master && transmit_receive_select && sclRise && sdaDrive != sdaS
    |=> status_r[sbs_pkg::ST_ALOV])
    else $error("arbitration loss missed");
  AST_OVR: assert property (@(posedge clk) disable iff (!rstN_r)
    syncLast && status_r[sbs_pkg::ST_RECEIVE_DATA_FULL_FLAG] |=> status_r[sbs_pkg::ST_ALOV])
    else $error("overrun missed");
  AST_RECEIVE_DATA_FULL_FLAG_CLR: assert property (@(posedge clk) disable iff (!rstN_r)
    rxRead && !rxDone |=> !status_r[sbs_pkg::ST_RECEIVE_DATA_FULL_FLAG])
    else $error("receive full not cleared by read");
  AST_TRANSMIT_END_FLAG: assert property (@(posedge clk) disable iff (!rstN_r)
    ninth && status_r[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG] |=> status_r[sbs_pkg::ST_TRANSMIT_END_FLAG])
    else $error("transmit end missed at ninth clock");
  AST_TRANSMIT_DATA_EMPTY_FLAG_LOAD: assert property (@(posedge clk) disable iff (!rstN_r)
    s_load |=> status_r[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG])
    else $error("transmit empty missed on load");
  AST_TXW: assert property (@(posedge clk) disable iff (!rstN_r)
    s_txw ##0 !txLoad && !trsSetSw && !ownStart && !toSlaveTx && !ninth
    |=> !status_r[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG] && !status_r[sbs_pkg::ST_TRANSMIT_END_FLAG])
    else $error("transmit write did not clear flags");
  AST_TXI: assert property (@(posedge clk) disable iff (!rstN_r)
    ien_r[sbs_pkg::IE_TIE] && $past(ien_r[sbs_pkg::IE_TIE])
    && status_r[sbs_pkg::ST_TRANSMIT_DATA_EMPTY_FLAG] && !txWrite
    |-> req.txEmpty)
    else $error("transmit empty request missing");
  AST_W1: assert property (@(posedge clk) disable iff (!rstN_r)
    wrAcc && paddr == sbs_pkg::ADDR_STATUS && pwdata[7:0] == 8'hff
    |=> status_r == $past(status_r | setVec))
    else $error("write of ones changed flags");
endmodule // sbs_flag_logic
`default_nettype wire

/* tb/sbs_bus_partner.sv */
// bus partner: another device on scl and sda, open drain with pull-ups
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_partner (
  // lines as this device drives them, 1 = released
  output logic sclOut,
  output logic sdaOut
);
  localparam int HALF = 80;
  // idle bus: both lines pulled high, scl stands still between frames
  initial begin
    sclOut = 1'b1;
    sdaOut = 1'b1;
  end
  // start: sda falls while scl high; odd offset keeps phase unrelated
  task automatic start();
    #7 sdaOut = 1'b0;
    #HALF sclOut = 1'b0;
  endtask
  // one bit: data changes only while scl is low
  task automatic bitOut(input logic b);
    sdaOut = b;
    #(HALF/2) sclOut = 1'b1;
    #HALF sclOut = 1'b0;
    #(HALF/2);
  endtask
  // stop: sda rises while scl high, then the bus rests
  task automatic stop();
    sdaOut = 1'b0;
    #(HALF/2) sclOut = 1'b1;
    #HALF sdaOut = 1'b1;
    #HALF;
  endtask
endmodule // sbs_bus_partner
`default_nettype wire

/* tb/tb.sv */
// self-checking bench of the serial bus status flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, resetN, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, rxByte, txData;
  logic [31:0] pwdata, prdata, r;
  logic sclIn, sdaIn, sclLine, sdaLine, selectInA, selectInB, sdaDrive;
  logic rxDone, rxFirst, txLoad, i2cSelect, slaveSelect;
  logic [7:0] pm;
  sbs_pkg::sbs_req_t req;
  int miscompares = 0;
  int nCompared = 0;
  int cycles = 0;
  int expSt, expRx, ien;

  assign sclIn = sclLine;
  assign sdaIn = sdaLine & sdaDrive;

  sbs_flag_logic uut (.clk(clk), .reset_n(resetN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn),
    .sdaIn(sdaIn), .selectInA(selectInA), .selectInB(selectInB),
    .sdaDrive(sdaDrive), .rxDone(rxDone), .rxByte(rxByte),
    .rxFirst(rxFirst), .txLoad(txLoad), .txData(txData),
    .i2cSelect(i2cSelect), .slaveSelect(slaveSelect), .req(req));

  sbs_bus_partner partner (.sclOut(sclLine), .sdaOut(sdaLine));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    if (miscompares == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // run length guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // status and request lines against the model
  task automatic checkSt();
    logic [7:0] s;
    logic [4:0] n;
    s = expSt[7:0];
    n = ien[4:0];
    apb(1'b0, sbs_pkg::ADDR_STATUS, 32'h0);
    chk("status", r, {24'h0, s});
    chk("req", {27'h0, req}, {27'h0, s[7] & n[0], s[6] & n[1],
      s[5] & n[2], s[3] & n[3], (s[2] | s[4]) & n[4]});
  endtask

  task automatic rx(input logic f, input logic [7:0] b);
    rxFirst <= f;
    rxByte <= b;
    rxDone <= 1'b1;
    @(posedge clk);
    rxDone <= 1'b0;
    rxFirst <= 1'b0;
    idle(2);
    expSt = expSt | 'h20;
    expRx = b;
  endtask

  initial begin
    resetN = 1'b0;
    {psel, penable, pwrite, rxDone, rxFirst, txLoad} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rxByte = 8'h00;
    {selectInA, selectInB, sdaDrive} = 3'h1;
    expSt = 0;
    ien = 0;
    void'($urandom(32'h9e23));
    idle(3);
    resetN <= 1'b1;
    idle(3);
    checkSt();
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", r, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("pready", {31'h0, pready}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      pm = (i == 0) ? 8'h88 : 8'h00;
      apb(1'b1, sbs_pkg::ADDR_PORTMODE, {24'h0, pm});
      apb(1'b0, sbs_pkg::ADDR_PORTMODE, 32'h0);
      chk("portmode", r, {24'h0, pm});
      selectInA <= 1'($urandom);
      idle(1);
      selectInB <= ~selectInA;
      idle(5);
      chk("i2csel", {31'h0, i2cSelect}, {31'h0, pm[7]});
      chk("ssel", {31'h0, slaveSelect},
        {31'h0, pm[3] ? selectInB : selectInA});
    end
    // master transmit with ack check, all requests enabled
    ien = 'h1f;
    apb(1'b1, sbs_pkg::ADDR_IEN, 32'h1f);
    apb(1'b1, sbs_pkg::ADDR_CTRL, 32'h0e);
    expSt = 'h80;
    checkSt();
    apb(1'b1, sbs_pkg::ADDR_TXDATA, 32'h5a);
    expSt = 0;
    checkSt();
    chk("txdata", {24'h0, txData}, 32'h5a);
    txLoad <= 1'b1;
    @(posedge clk);
    txLoad <= 1'b0;
    idle(2);
    expSt = 'h80;
    checkSt();
    partner.start();
    for (int i = 0; i < 9; i++) partner.bitOut(1'b1);
    partner.stop();
    @(posedge clk);
    idle(6);
    expSt = 'hdc;
    checkSt();
    apb(1'b1, sbs_pkg::ADDR_STATUS, 32'hff);
    checkSt();
    apb(1'b1, sbs_pkg::ADDR_STATUS, 32'h0);
    expSt = 0;
    checkSt();
    // own start, then a lost bit and a stop without a full frame
    sdaDrive <= 1'b0;
    idle(6);
    expSt = 'h80;
    checkSt();
    partner.start();
    @(posedge clk);
    sdaDrive <= 1'b1;
    partner.bitOut(1'b0);
    partner.stop();
    @(posedge clk);
    idle(6);
    expSt = 'h84;
    checkSt();
    apb(1'b1, sbs_pkg::ADDR_STATUS, 32'h0);
    expSt = 0;
    // slave receive, own address 5a
    ien = $urandom & 'h1f;
    apb(1'b1, sbs_pkg::ADDR_IEN, ien);
    apb(1'b1, sbs_pkg::ADDR_CTRL, 32'h5a00);
    expSt = 'h01;
    rx(1'b1, 8'h00);
    checkSt();
    apb(1'b0, sbs_pkg::ADDR_RXDATA, 32'h0);
    chk("rxdata", r, expRx);
    expSt = 'h01;
    checkSt();
    rx(1'b1, 8'hb5);
    expSt = 'ha3;
    checkSt();
    rx(1'b0, 8'($urandom));
    checkSt();
    apb(1'b0, sbs_pkg::ADDR_RXDATA, 32'h0);
    chk("rxdata", r, expRx);
    expSt = 'h83;
    checkSt();
    // clock synchronous format, transmit select on, receive full left set
    apb(1'b1, sbs_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, sbs_pkg::ADDR_CTRL, 32'h05);
    expSt = 0;
    rx(1'b0, 8'($urandom));
    checkSt();
    partner.start();
    for (int i = 0; i < 8; i++) partner.bitOut(1'($urandom));
    partner.stop();
    @(posedge clk);
    idle(6);
    expSt = 'h64;
    checkSt();
    conclude();
  end
endmodule // tb
`default_nettype wire
